// ---- hw/sdpi_defines.svh ----
// sdpi_defines.svh: widths, field positions, reset values and latencies
// of the synchronous DRAM pin command interface.
// assumes it is included by bare name before the design files.
`ifndef SDPI_DEFINES_SVH
`define SDPI_DEFINES_SVH

`define SDPI_ADDR_W     11
`define SDPI_COL_W      8
`define SDPI_DQ_W       32
`define SDPI_BANK_W     2
`define SDPI_AP_BIT     10
`define SDPI_BL_MSB     2
`define SDPI_BL_LSB     0
`define SDPI_BL_FULL    3'h7
`define SDPI_BEATS_FULL 9'h100
`define SDPI_MODE_RST   11'h000
`define SDPI_MASK_LAT   2

`endif

// ---- hw/sdpi_pkg.sv ----
// sdpi_pkg: command and power-state types of the DRAM pin interface.
// assumes nothing beyond a SystemVerilog compiler.
package sdpi_pkg;

    // code is {row strobe, column strobe, write enable}, all active low
    typedef enum logic [2:0] {
        CMD_MRS = 3'b000,
        CMD_REF = 3'b001,
        CMD_PRE = 3'b010,
        CMD_ACT = 3'b011,
        CMD_WR  = 3'b100,
        CMD_RD  = 3'b101,
        CMD_BST = 3'b110,
        CMD_NOP = 3'b111
    } sdpi_cmd_e;

    typedef enum logic [1:0] {
        PWR_RUN      = 2'b00,
        PWR_DOWN     = 2'b01,
        PWR_SUSPEND  = 2'b10,
        PWR_SELF_REF = 2'b11
    } sdpi_pwr_e;

endpackage

// ---- hw/sdpi_sync.sv ----
// sdpi_sync: three-stage synchroniser for one asynchronous level.
// assumes core_clk is free running; output moves once stages 2 and 3 agree.
`timescale 1ns/10ps
`default_nettype none

module sdpi_sync (
    input  wire logic core_clk,  // sampling clock
    input  wire logic rst_n,     // async reset, active low
    input  wire logic async_in,  // level from another domain
    output logic      level_out  // filtered, synchronous level
);

    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // a single-cycle glitch never reaches the output
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            level_out <= 1'b0;
        end else if (s2 == s3) begin
            level_out <= s3;
        end
    end

endmodule

`default_nettype wire

// ---- hw/sdpi_pin_if.sv ----
// sdpi_pin_if: command decode, address capture, bank state, burst walk,
// byte masking and power state of a four-bank 32-bit synchronous DRAM.
// assumes command pins are synchronous to core_clk; cke is asynchronous.
// Behaviour
// - activate captures all address bits as row
// - read/write takes low address bits as column
// - top address bit requests close after burst
// - precharge: top bit all banks, else one
// - mode load copies address inputs to mode
// - bank-select picks bank for bank commands
// - command decoded from three strobes together
// - strobe encodings for the eight commands
// - edges with clock enable low are ignored; code still takes four more edges after it falls
// - clock enable low: down, suspend, self refresh
// - clock enable asynchronous, others sampled rising
// - chip select high ignores command inputs
// - each mask bit governs one byte lane
// - read mask high floats its lane
// - write mask high keeps stored byte
// - read mask acts two clocks later
`include "sdpi_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module sdpi_pin_if
    import sdpi_pkg::*;
#(
    parameter int ADDR_W = `SDPI_ADDR_W,
    parameter int COL_W  = `SDPI_COL_W,
    parameter int DQ_W   = `SDPI_DQ_W
) (
    input  wire logic                      core_clk,    // system clock, rising edge
    input  wire logic                      rst_n,       // async reset, active low
    input  wire logic                      cke,         // clock enable pin, async
    input  wire logic                      cs_n,        // chip select, active low
    input  wire logic                      ras_n,       // row strobe, active low
    input  wire logic                      cas_n,       // column strobe, active low
    input  wire logic                      we_n,        // write enable, active low
    input  wire logic [ADDR_W-1:0]         addr_in,     // address inputs
    input  wire logic [`SDPI_BANK_W-1:0]   bank_sel,    // bank select
    input  wire logic [DQ_W/8-1:0]         byte_mask,   // byte masks
    input  wire logic [DQ_W-1:0]           data_io_in,  // data pins, input side
    output logic      [DQ_W-1:0]           data_io_out, // data pins, output side
    output logic      [DQ_W/8-1:0]         data_io_oe,  // per-lane drive enable
    input  wire logic [DQ_W-1:0]           rd_data,     // array word at burst_col
    output logic                           cmd_valid,   // command taken at last enabled edge
    output sdpi_cmd_e                      cmd_code,    // last taken command
    output logic      [ADDR_W-1:0]         row_addr,    // captured row
    output logic      [COL_W-1:0]          col_addr,    // captured start column
    output logic      [`SDPI_BANK_W-1:0]   cmd_bank,    // captured bank
    output logic                           auto_pre,    // close after burst
    output logic                           pre_all,     // last precharge hit all
    output logic      [ADDR_W-1:0]         mode_reg,    // mode register
    output logic      [3:0]                bank_open,   // row open per bank
    output logic                           burst_active,// burst beat this cycle
    output logic                           burst_write, // burst is a write
    output logic      [`SDPI_BANK_W-1:0]   burst_bank,  // bank of burst
    output logic      [COL_W-1:0]          burst_col,   // column of this beat
    output logic                           wr_valid,    // write beat stored
    output logic      [DQ_W-1:0]           wr_data,     // write beat data
    output logic      [DQ_W/8-1:0]         wr_byte_en,  // lanes to store
    output logic      [COL_W-1:0]          wr_col,      // write beat column
    output logic      [`SDPI_BANK_W-1:0]   wr_bank,     // write beat bank
    output sdpi_pwr_e                      pwr_state    // low-power state
);

    localparam int LANES = DQ_W / 8;

    initial begin
        if (ADDR_W <= `SDPI_AP_BIT || COL_W >= ADDR_W || COL_W > 8 || DQ_W % 8 != 0 || DQ_W < 8) begin
            $error("sdpi_pin_if: unsupported width parameters");
        end
    end

    logic            cke_ok;
    logic            cmd_sel;
    sdpi_cmd_e       in_cmd;
    logic            ap_bit;
    logic            burst_ap;
    logic            burst_full;
    logic [8:0]      burst_left;
    logic            burst_end;
    logic            rd_beat;
    logic [LANES-1:0] mask_pipe [`SDPI_MASK_LAT];

    sdpi_sync u_cke_sync (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .async_in  (cke),
        .level_out (cke_ok)
    );

    assign cmd_sel = cke_ok && !cs_n;
    assign in_cmd  = sdpi_cmd_e'({ras_n, cas_n, we_n});
    assign ap_bit  = addr_in[`SDPI_AP_BIT];

    function automatic logic [8:0] bl_beats(input logic [2:0] f);
        case (f)
            3'h0:    bl_beats = 9'h001;
            3'h1:    bl_beats = 9'h002;
            3'h2:    bl_beats = 9'h004;
            3'h3:    bl_beats = 9'h008;
            default: bl_beats = `SDPI_BEATS_FULL;
        endcase
    endfunction

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_valid <= 1'b0;
            cmd_code  <= CMD_NOP;
        end else if (cke_ok) begin
            cmd_valid <= !cs_n;
            if (!cs_n) begin
                cmd_code <= in_cmd;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            row_addr <= '0;
            col_addr <= '0;
            cmd_bank <= '0;
            auto_pre <= 1'b0;
            pre_all  <= 1'b0;
        end else if (cmd_sel) begin
            case (in_cmd)
                CMD_ACT: begin
                    row_addr <= addr_in;
                    cmd_bank <= bank_sel;
                end
                CMD_RD, CMD_WR: begin
                    col_addr <= addr_in[COL_W-1:0];
                    auto_pre <= ap_bit;
                    cmd_bank <= bank_sel;
                end
                CMD_PRE: begin
                    pre_all  <= ap_bit;
                    cmd_bank <= bank_sel;
                end
                default: begin
                    cmd_bank <= cmd_bank;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= ADDR_W'(`SDPI_MODE_RST);
        end else if (cmd_sel && in_cmd == CMD_MRS) begin
            mode_reg <= addr_in;
        end
    end

    assign burst_end = cke_ok && burst_active && !burst_full && burst_left == 9'h001;

    for (genvar b = 0; b < 4; b++) begin : g_bank
        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                bank_open[b] <= 1'b0;
            end else if (cke_ok) begin
                if (cmd_sel && in_cmd == CMD_ACT && bank_sel == `SDPI_BANK_W'(b)) begin
                    bank_open[b] <= 1'b1;
                end else if (cmd_sel && in_cmd == CMD_PRE && (ap_bit || bank_sel == `SDPI_BANK_W'(b))) begin
                    bank_open[b] <= 1'b0;
                end else if (burst_end && burst_ap && burst_bank == `SDPI_BANK_W'(b)) begin
                    bank_open[b] <= 1'b0;
                end
            end
        end
    end

    // beats start the edge after the command; a new read or write, or a burst stop, cuts the old burst
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            burst_active <= 1'b0;
            burst_write  <= 1'b0;
            burst_bank   <= '0;
            burst_col    <= '0;
            burst_ap     <= 1'b0;
            burst_full   <= 1'b0;
            burst_left   <= 9'h000;
        end else if (cke_ok) begin
            if (cmd_sel && (in_cmd == CMD_RD || in_cmd == CMD_WR)) begin
                burst_active <= 1'b1;
                burst_write  <= (in_cmd == CMD_WR);
                burst_bank   <= bank_sel;
                burst_col    <= addr_in[COL_W-1:0];
                burst_ap     <= ap_bit;
                burst_full   <= (mode_reg[`SDPI_BL_MSB:`SDPI_BL_LSB] == `SDPI_BL_FULL);
                burst_left   <= bl_beats(mode_reg[`SDPI_BL_MSB:`SDPI_BL_LSB]);
            end else if (cmd_sel && in_cmd == CMD_BST) begin
                burst_active <= 1'b0;
            end else if (burst_active) begin
                burst_col  <= COL_W'(burst_col + 1'b1);
                burst_left <= 9'(burst_left - 1'b1);
                if (burst_end) begin
                    burst_active <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_valid   <= 1'b0;
            wr_data    <= '0;
            wr_byte_en <= '0;
            wr_col     <= '0;
            wr_bank    <= '0;
        end else if (cke_ok) begin
            wr_valid   <= burst_active && burst_write;
            wr_data    <= data_io_in;
            wr_byte_en <= ~byte_mask;
            wr_col     <= burst_col;
            wr_bank    <= burst_bank;
        end
    end

    assign rd_beat = burst_active && !burst_write;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `SDPI_MASK_LAT; i++) begin
                mask_pipe[i] <= '1;
            end
            data_io_out <= '0;
        end else if (cke_ok) begin
            mask_pipe[0] <= byte_mask;
            for (int i = 1; i < `SDPI_MASK_LAT; i++) begin
                mask_pipe[i] <= mask_pipe[i-1];
            end
            data_io_out <= rd_data;
        end
    end

    for (genvar l = 0; l < LANES; l++) begin : g_lane
        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                data_io_oe[l] <= 1'b0;
            end else if (cke_ok) begin
                data_io_oe[l] <= rd_beat && !mask_pipe[`SDPI_MASK_LAT-1][l];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_state <= PWR_RUN;
        end else begin
            case (pwr_state)
                PWR_RUN: begin
                    if (!cke_ok && burst_active) begin
                        pwr_state <= PWR_SUSPEND;
                    end else if (!cke_ok && cmd_valid && cmd_code == CMD_REF) begin
                        pwr_state <= PWR_SELF_REF;
                    end else if (!cke_ok) begin
                        pwr_state <= PWR_DOWN;
                    end
                end
                PWR_DOWN, PWR_SUSPEND, PWR_SELF_REF: begin
                    if (cke_ok) begin
                        pwr_state <= PWR_RUN;
                    end
                end
                default: begin
                    pwr_state <= PWR_RUN;
                end
            endcase
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence act_issue;
        cmd_sel && in_cmd == CMD_ACT;
    endsequence
    sequence rw_issue;
        cmd_sel && (in_cmd == CMD_RD || in_cmd == CMD_WR);
    endsequence
    sequence lane0_masked;
        cke_ok && byte_mask[0] ##1 cke_ok ##1 cke_ok;
    endsequence

    row_capture_a: assert property (act_issue |=> row_addr == $past(addr_in) && cmd_code == CMD_ACT)
        else $error("row not captured on activate");
    col_start_a: assert property (rw_issue |=> col_addr == $past(addr_in[COL_W-1:0]) && burst_col == col_addr)
        else $error("start column wrong");
    auto_close_a: assert property (burst_end && burst_ap && !act_issue |=> !bank_open[$past(burst_bank)])
        else $error("auto close did not close bank");
    pre_all_a: assert property (cmd_sel && in_cmd == CMD_PRE && ap_bit |=> bank_open == 4'h0)
        else $error("precharge all left a bank open");
    mode_load_a: assert property (cmd_sel && in_cmd == CMD_MRS |=> mode_reg == $past(addr_in))
        else $error("mode register not loaded");
    bank_target_a: assert property (act_issue |=> bank_open[$past(bank_sel)] && cmd_bank == $past(bank_sel))
        else $error("activate hit wrong bank");
    read_decode_a: assert property (cmd_sel && ras_n && !cas_n && we_n |=> burst_active && !burst_write)
        else $error("read encoding not decoded");
    freeze_hold_a: assert property (!cke_ok |=> $stable(mode_reg) && $stable(bank_open) && $stable(burst_col))
        else $error("state moved with clock enable low");
    low_power_a: assert property (!cke_ok ##1 !cke_ok |-> pwr_state != PWR_RUN)
        else $error("no low-power state with clock enable low");
    cke_sync_a: assert property ((!cke)[*4] |=> !cke_ok)
        else $error("clock enable low not seen in time");
    deselect_a: assert property (cke_ok && cs_n && !burst_end |=> !cmd_valid && $stable(mode_reg) && $stable(bank_open))
        else $error("command taken while deselected");
    read_mask_a: assert property (lane0_masked |=> !data_io_oe[0])
        else $error("masked read lane driven");
    write_mask_a: assert property (cke_ok && burst_active && burst_write && byte_mask[3] |=> wr_valid && !wr_byte_en[3])
        else $error("masked write lane stored");

endmodule

`default_nettype wire

// ---- testbench/sdpi_ctrl_model.sv ----
// sdpi_ctrl_model: behavioural memory controller driving the command pins.
// assumes callers enter its tasks just after a rising edge of core_clk.
`timescale 1ns/10ps
`default_nettype none

module sdpi_ctrl_model
    import sdpi_pkg::*;
(
    input  wire logic   core_clk,   // system clock
    output logic        cs_n,       // chip select
    output logic        ras_n,      // row strobe
    output logic        cas_n,      // column strobe
    output logic        we_n,       // write enable
    output logic [10:0] addr_in,    // address pins
    output logic [1:0]  bank_sel,   // bank select
    output logic [3:0]  byte_mask,  // lane masks
    output logic [31:0] data_io_in  // write data
);
    initial begin
        cs_n = 1'b1;
        {ras_n, cas_n, we_n} = CMD_NOP;
        addr_in = 11'h000;
        bank_sel = 2'h0;
        byte_mask = 4'hF;
        data_io_in = 32'h5A5A5A5A;
    end

    task automatic send(input logic cs, input sdpi_cmd_e c, input logic [1:0] b,
                        input logic [10:0] a, input logic [3:0] m);
        cs_n = cs;
        {ras_n, cas_n, we_n} = c;
        bank_sel = b;
        addr_in = a;
        byte_mask = m;
        @(posedge core_clk);
        #2;
    endtask

    // one data beat, command pins at no-op
    task automatic beat(input logic [31:0] d, input logic [3:0] m);
        cs_n = 1'b0;
        {ras_n, cas_n, we_n} = CMD_NOP;
        data_io_in = d;
        byte_mask = m;
        @(posedge core_clk);
        #2;
    endtask

    task automatic idle(input int n);
        cs_n = 1'b0;
        {ras_n, cas_n, we_n} = CMD_NOP;
        // released bus shows inverse, not a stale copy
        data_io_in = ~data_io_in;
        // address pins are don't-care under no-op
        addr_in = ~addr_in;
        bank_sel = ~bank_sel;
        repeat (n) @(posedge core_clk);
        #2;
    endtask
endmodule
`default_nettype wire

// ---- testbench/sdpi_pin_if_bench.sv ----
// sdpi_pin_if_bench: self-checking scenarios for the DRAM pin interface.
// assumes sdpi_pkg compiled first; controller model drives the command pins.
`timescale 1ns/10ps
`default_nettype none

module sdpi_pin_if_bench
    import sdpi_pkg::*;
;
    logic core_clk, rst_n, cke, cs_n, ras_n, cas_n, we_n;
    logic [10:0] addr_in, row_addr, mode_reg;
    logic [1:0]  bank_sel, cmd_bank, burst_bank, wr_bank;
    logic [3:0]  byte_mask, data_io_oe, bank_open, wr_byte_en;
    logic [31:0] data_io_in, data_io_out, rd_data, wr_data;
    logic [7:0]  col_addr, burst_col, wr_col;
    logic        cmd_valid, auto_pre, pre_all, burst_active, burst_write, wr_valid;
    sdpi_cmd_e   cmd_code;
    sdpi_pwr_e   pwr_state;
    int          err_count = 0;
    int          num_checks = 0;
    int          cycles = 0;

    // array word tagged with bank and column
    function automatic logic [31:0] word(input logic [1:0] b, input logic [7:0] c);
        return {8'hC3, 6'h00, b, 8'h5A, c};
    endfunction
    assign rd_data = word(burst_bank, burst_col);

    sdpi_pin_if i_sdpi_pin_if (.core_clk(core_clk), .rst_n(rst_n), .cke(cke), .cs_n(cs_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr_in(addr_in), .bank_sel(bank_sel),
        .byte_mask(byte_mask), .data_io_in(data_io_in), .data_io_out(data_io_out),
        .data_io_oe(data_io_oe), .rd_data(rd_data), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .row_addr(row_addr), .col_addr(col_addr), .cmd_bank(cmd_bank), .auto_pre(auto_pre),
        .pre_all(pre_all), .mode_reg(mode_reg), .bank_open(bank_open),
        .burst_active(burst_active), .burst_write(burst_write), .burst_bank(burst_bank),
        .burst_col(burst_col), .wr_valid(wr_valid), .wr_data(wr_data),
        .wr_byte_en(wr_byte_en), .wr_col(wr_col), .wr_bank(wr_bank), .pwr_state(pwr_state));

    sdpi_ctrl_model i_sdpi_ctrl_model (.core_clk(core_clk), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .addr_in(addr_in), .bank_sel(bank_sel),
        .byte_mask(byte_mask), .data_io_in(data_io_in));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        if (err_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            end_of_test();
        end
    end

    task automatic s_codes();
        sdpi_cmd_e seq [8] = '{CMD_NOP, CMD_BST, CMD_REF, CMD_MRS, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE};
        // full page write, cut short by burst stop
        i_sdpi_ctrl_model.send(1'b0, CMD_MRS, 2'h0, 11'h007, 4'h0);
        i_sdpi_ctrl_model.send(1'b0, CMD_WR, 2'h0, 11'h0FF, 4'h0);
        i_sdpi_ctrl_model.beat(32'hCAFE0001, 4'b1000);
        check({burst_active, burst_col, wr_col, wr_byte_en}, {1'b1, 8'h00, 8'hFF, 4'b0111});
        i_sdpi_ctrl_model.send(1'b0, CMD_BST, 2'h0, 11'h000, 4'h0);
        check({burst_active, cmd_code}, {1'b0, CMD_BST});
        foreach (seq[i]) begin
            i_sdpi_ctrl_model.send(1'b0, seq[i], 2'h0, 11'h000, 4'h0);
            check(cmd_code, seq[i]);
            check(cmd_valid, 1'b1);
        end
        i_sdpi_ctrl_model.idle(3);
    endtask

    task automatic s_rows();
        i_sdpi_ctrl_model.send(1'b0, CMD_MRS, 2'h3, 11'h401, 4'h0);
        check(mode_reg, 11'h401);
        i_sdpi_ctrl_model.send(1'b0, CMD_ACT, 2'h1, 11'h7FF, 4'h0);
        check({row_addr, cmd_bank, bank_open}, {11'h7FF, 2'h1, 4'b0010});
        i_sdpi_ctrl_model.send(1'b0, CMD_ACT, 2'h2, 11'h2AA, 4'h0);
        check({row_addr, cmd_bank, bank_open}, {11'h2AA, 2'h2, 4'b0110});
    endtask

    task automatic s_write();
        i_sdpi_ctrl_model.send(1'b0, CMD_WR, 2'h1, 11'h304, 4'h0);
        check({col_addr, auto_pre, burst_active, burst_write, burst_col}, {8'h04, 3'b011, 8'h04});
        check(burst_bank, 2'h1);
        i_sdpi_ctrl_model.beat(32'h11223344, 4'b0101);
        check({wr_valid, wr_byte_en, wr_col, wr_bank}, {1'b1, 4'b1010, 8'h04, 2'h1});
        check(wr_data, 32'h11223344);
        i_sdpi_ctrl_model.beat(32'hAABBCCDD, 4'b0000);
        check({wr_valid, wr_byte_en, wr_col, burst_active}, {1'b1, 4'hF, 8'h05, 1'b0});
        i_sdpi_ctrl_model.idle(2);
    endtask

    task automatic s_read();
        // mask on the pins two edges ahead of each output beat
        i_sdpi_ctrl_model.send(1'b0, CMD_NOP, 2'h2, 11'h000, 4'b0011);
        i_sdpi_ctrl_model.send(1'b0, CMD_RD, 2'h2, 11'h010, 4'b1100);
        i_sdpi_ctrl_model.beat(32'h0, 4'h0);
        check(data_io_oe, 4'b1100);
        check(data_io_out[31:16], word(2'h2, 8'h10) >> 16);
        i_sdpi_ctrl_model.idle(1);
        check(data_io_oe, 4'b0011);
        check(data_io_out[15:0], word(2'h2, 8'h11) & 32'h0000FFFF);
        i_sdpi_ctrl_model.send(1'b0, CMD_RD, 2'h1, 11'h405, 4'h0);
        check({auto_pre, col_addr}, {1'b1, 8'h05});
        i_sdpi_ctrl_model.idle(3);
        check(bank_open, 4'b0100);
    endtask

    task automatic s_pre();
        i_sdpi_ctrl_model.send(1'b0, CMD_ACT, 2'h0, 11'h001, 4'h0);
        i_sdpi_ctrl_model.send(1'b0, CMD_ACT, 2'h3, 11'h002, 4'h0);
        i_sdpi_ctrl_model.send(1'b0, CMD_PRE, 2'h2, 11'h000, 4'h0);
        check({bank_open, pre_all}, {4'b1001, 1'b0});
        i_sdpi_ctrl_model.send(1'b0, CMD_PRE, 2'h3, 11'h3FF, 4'h0);
        check({bank_open, pre_all}, {4'b0001, 1'b0});
        i_sdpi_ctrl_model.send(1'b0, CMD_ACT, 2'h3, 11'h002, 4'h0);
        i_sdpi_ctrl_model.send(1'b0, CMD_PRE, 2'h1, 11'h400, 4'h0);
        check({bank_open, pre_all}, {4'b0000, 1'b1});
        i_sdpi_ctrl_model.send(1'b1, CMD_ACT, 2'h2, 11'h155, 4'h0);
        i_sdpi_ctrl_model.send(1'b1, CMD_MRS, 2'h2, 11'h155, 4'h0);
        check({bank_open, cmd_valid, mode_reg}, {4'b0000, 1'b0, 11'h401});
    endtask

    task automatic s_cke();
        i_sdpi_ctrl_model.idle(2);
        cke = 1'b0;
        i_sdpi_ctrl_model.idle(6);
        check(pwr_state, PWR_DOWN);
        i_sdpi_ctrl_model.send(1'b0, CMD_ACT, 2'h1, 11'h010, 4'h0);
        i_sdpi_ctrl_model.idle(1);
        check(bank_open, 4'b0000);
        cke = 1'b1;
        i_sdpi_ctrl_model.idle(6);
        check(pwr_state, PWR_RUN);
        // refresh pins held so the last taken command stays refresh
        i_sdpi_ctrl_model.send(1'b0, CMD_REF, 2'h0, 11'h000, 4'h0);
        cke = 1'b0;
        repeat (7) @(posedge core_clk);
        #2;
        check(pwr_state, PWR_SELF_REF);
        i_sdpi_ctrl_model.idle(1);
        cke = 1'b1;
        i_sdpi_ctrl_model.idle(6);
        check(pwr_state, PWR_RUN);
        // mid-run reset, then clock enable must resync before commands count
        rst_n = 1'b0;
        i_sdpi_ctrl_model.idle(2);
        check({mode_reg, bank_open, cmd_valid, cmd_code}, {11'h000, 4'h0, 1'b0, CMD_NOP});
        rst_n = 1'b1;
        i_sdpi_ctrl_model.idle(6);
        check(pwr_state, PWR_RUN);
    endtask

    initial begin
        rst_n = 1'b0;
        cke = 1'b1;
        repeat (12) @(posedge core_clk);
        #2;
        rst_n = 1'b1;
        i_sdpi_ctrl_model.idle(6);
        s_codes();
        s_rows();
        s_write();
        s_read();
        s_pre();
        s_cke();
        end_of_test();
    end
endmodule
`default_nettype wire
